// file: core/astpg_defs.vh
// astpg_defs.vh: constants for the serial test pattern generator
// assumes: included by the generator module, its assertion module and its testbench
`ifndef ASTPG_DEFS_VH
`define ASTPG_DEFS_VH
// ----------------------------------------
// pattern select codes
// ----------------------------------------
`define ASTPG_PAT_NONE 3'h0
`define ASTPG_PAT_ZEROS 3'h1
`define ASTPG_PAT_ONES 3'h2
`define ASTPG_PAT_TOGGLE 3'h3
`define ASTPG_PAT_CUSTOM 3'h4
`define ASTPG_PAT_SYNC 3'h5
`define ASTPG_PAT_DESKEW 3'h6
// ----------------------------------------
// interface options
// ----------------------------------------
`define ASTPG_IF_1W_DDR 2'h0
`define ASTPG_IF_2W_DDR 2'h1
`define ASTPG_IF_2W_SDR 2'h2
`define ASTPG_ORD_BYTE 2'h0
`define ASTPG_ORD_BIT 2'h1
`define ASTPG_ORD_WORD 2'h2
// ----------------------------------------
// fixed words and latencies
// ----------------------------------------
`define ASTPG_TOGGLE_A 14'h2aaa
`define ASTPG_TOGGLE_B 14'h1555
`define ASTPG_SYNC_1W14 14'h3f80
`define ASTPG_SYNC_1W16 16'hff80
`define ASTPG_SYNC_2W14 7'h78
`define ASTPG_SYNC_2W16 8'hf0
`define ASTPG_ADC_LAT 12
`define ASTPG_MAX_LAT 14
`endif

// file: core/astpg_gen.v
// astpg_gen.v: pattern mux, latency pipe and serializer for two channels
// assumes: i_clk is the bit clock (one bit per edge), i_frame_tick is a one-cycle
// sample-rate enable from a divider; i_sample_* is on the i_clk domain.
//
// Overview of operation
// RULE1: bit clock output toggles mid-bit, half a bit after each data change; code toggles it on the same i_clk edge as the data.
// RULE2: deskew mode drives alternating ones and zeros on every data wire.
// RULE3: receiver uses deskew to tune its capture edge and skew.
// RULE4: sync mode sends run of ones then zeros per wire, per option.
// RULE5: receiver slips deserialized bits until sync word matches.
// RULE6: chosen pattern goes on all four wires of both channels together.
// RULE7: zeros mode holds wires low; ones mode holds wires high.
// RULE8: toggle mode alternates 1010 and 0101 words each sample.
// RULE9: custom mode serializes the programmed 14-bit word every sample.
// RULE10: two-wire custom word split like converted samples.
// RULE11: custom and sync follow width, factor and order; constants do not.
// RULE12: total latency is 12 sample clocks plus serializer latency.
// RULE13: one-wire DDR adds zero serializer cycles.
// RULE14: two-wire DDR adds 2/1 at 14x, 1/0 at 16x, by prop delay.
// RULE15: two-wire SDR adds zero serializer cycles.
// RULE16: byte-wise: low wire seven LSBs, high wire seven MSBs.
// RULE17: MSB first after reset; LSB-first reverses order on each wire.
// RULE18: pattern replaces sample; frame and bit clock unchanged.
// RULE19: no pattern selected: converted samples serialized normally.
`timescale 1ns/1ps
`include "astpg_defs.vh"
module astpg_gen #(
  parameter DW = 14
) (
  // clock and reset
  input wire i_clk,
  input wire i_srst,
  input wire i_frame_tick,
  // samples
  input wire [DW-1:0] i_sample_a,
  input wire [DW-1:0] i_sample_b,
  // configuration
  input wire [2:0] i_pattern_sel,
  input wire [1:0] i_if_mode,
  input wire i_ser16,
  input wire [1:0] i_bit_order,
  input wire i_lsb_first,
  input wire i_clock_prop_delay_ge_ts,
  input wire [7:0] i_custom_hi,
  input wire [5:0] i_custom_lo,
  // serial outputs
  output reg o_serial_bit_clock_out,
  output reg o_frame_clock,
  output reg o_chan_a_wire_low,
  output reg o_chan_a_wire_high,
  output reg o_chan_b_wire_low,
  output reg o_chan_b_wire_high
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function [15:0] rev16;
    input [15:0] v;
    integer k;
    begin
      for (k = 0; k < 16; k = k + 1) begin
        rev16[k] = v[15-k];
      end
    end
  endfunction
  // map a 14-bit word to two 8-bit wire words (msb-aligned at 14x; at 16x right justified, bit 7 zero)
  function [15:0] split2;
    input [13:0] w;
    input [1:0] ord;
    input s16;
    integer k;
    reg [7:0] lo;
    reg [7:0] hi;
    begin
      lo = 8'h00;
      hi = 8'h00;
      for (k = 0; k < 7; k = k + 1) begin
        if (ord == `ASTPG_ORD_BIT) begin
          lo[k] = w[2*k];
          hi[k] = w[2*k+1];
        end else begin
          lo[k] = w[k]; // [RULE16]
          hi[k] = w[k+7]; // [RULE16]
        end
      end
      if (!s16) begin
        lo = {lo[6:0], 1'b0};
        hi = {hi[6:0], 1'b0};
      end
      split2 = {hi, lo};
    end
  endfunction
  // ----------------------------------------
  // latency pipeline of samples
  // ----------------------------------------
  reg [DW-1:0] pipe_a_r [0:`ASTPG_MAX_LAT-1];
  reg [DW-1:0] pipe_b_r [0:`ASTPG_MAX_LAT-1];
  reg [3:0] ser_lat;
  integer j;
  always @* begin
    ser_lat = 4'h0; // [RULE13] [RULE15]
    if (i_if_mode == `ASTPG_IF_2W_DDR) begin
      if (i_ser16) begin
        ser_lat = i_clock_prop_delay_ge_ts ? 4'h1 : 4'h0; // [RULE14]
      end else begin
        ser_lat = i_clock_prop_delay_ge_ts ? 4'h2 : 4'h1; // [RULE14]
      end
    end
  end
  always @(posedge i_clk) begin
    if (i_frame_tick) begin
      pipe_a_r[0] <= i_sample_a;
      pipe_b_r[0] <= i_sample_b;
      for (j = 1; j < `ASTPG_MAX_LAT; j = j + 1) begin
        pipe_a_r[j] <= pipe_a_r[j-1];
        pipe_b_r[j] <= pipe_b_r[j-1];
      end
    end
  end
  // sample entering at tick 0 leaves tap (12 + ser_lat - 1) -> [RULE12]
  wire [3:0] tap = 4'd11 + ser_lat;
  wire [DW-1:0] dly_a = pipe_a_r[tap];
  wire [DW-1:0] dly_b = pipe_b_r[tap];
  // ----------------------------------------
  // pattern select
  // ----------------------------------------
  reg toggle_r;
  reg word_odd_r;
  reg [13:0] word_a;
  reg [13:0] word_b;
  reg is_const;
  reg const_bit;
  reg is_sync;
  always @* begin
    word_a = dly_a; // [RULE19]
    word_b = dly_b;
    is_const = 1'b0;
    const_bit = 1'b0;
    is_sync = 1'b0;
    case (i_pattern_sel)
      `ASTPG_PAT_ZEROS: begin
        is_const = 1'b1; // [RULE7]
        const_bit = 1'b0;
      end
      `ASTPG_PAT_ONES: begin
        is_const = 1'b1; // [RULE7]
        const_bit = 1'b1;
      end
      `ASTPG_PAT_TOGGLE: begin
        word_a = toggle_r ? `ASTPG_TOGGLE_B : `ASTPG_TOGGLE_A; // [RULE8]
        word_b = word_a; // [RULE6]
      end
      `ASTPG_PAT_CUSTOM: begin
        word_a = {i_custom_hi, i_custom_lo}; // [RULE9]
        word_b = word_a; // [RULE6]
      end
      `ASTPG_PAT_SYNC: begin
        is_sync = 1'b1; // [RULE4]
      end
      default: begin
      end
    endcase
  end
  // ----------------------------------------
  // load shift registers on each frame tick
  // ----------------------------------------
  reg [15:0] sh_al_r;
  reg [15:0] sh_ah_r;
  reg [15:0] sh_bl_r;
  reg [15:0] sh_bh_r;
  reg [15:0] ld_al;
  reg [15:0] ld_ah;
  reg [15:0] ld_bl;
  reg [15:0] ld_bh;
  reg [15:0] sp;
  reg [15:0] one_a;
  reg [15:0] one_b;
  reg [15:0] sync_w;
  always @* begin
    sp = 16'h0000;
    one_a = i_ser16 ? {2'b00, word_a} : {word_a, 2'b00};
    one_b = i_ser16 ? {2'b00, word_b} : {word_b, 2'b00};
    if (i_if_mode == `ASTPG_IF_1W_DDR) begin
      sync_w = i_ser16 ? `ASTPG_SYNC_1W16 : {`ASTPG_SYNC_1W14, 2'b00};
    end else begin
      sync_w = i_ser16 ? {`ASTPG_SYNC_2W16, 8'h00} : {`ASTPG_SYNC_2W14, 9'h000};
    end
    ld_al = one_a;
    ld_ah = 16'h0000;
    ld_bl = one_b;
    ld_bh = 16'h0000;
    if (i_if_mode != `ASTPG_IF_1W_DDR) begin
      if (i_bit_order == `ASTPG_ORD_WORD) begin
        ld_al = {word_a, 2'b00};
        ld_bl = {word_b, 2'b00};
        ld_ah = ld_al;
        ld_bh = ld_bl;
      end else begin
        sp = split2(word_a, i_bit_order, i_ser16); // [RULE10] [RULE11]
        ld_al = {sp[7:0], 8'h00};
        ld_ah = {sp[15:8], 8'h00};
        sp = split2(word_b, i_bit_order, i_ser16);
        ld_bl = {sp[7:0], 8'h00};
        ld_bh = {sp[15:8], 8'h00};
      end
    end
    if (is_sync) begin
      ld_al = sync_w; // [RULE6]
      ld_ah = sync_w;
      ld_bl = sync_w;
      ld_bh = sync_w;
    end
  end
  // number of bits per wire per frame
  wire [4:0] nbits = (i_if_mode == `ASTPG_IF_1W_DDR || i_bit_order == `ASTPG_ORD_WORD) ?
                     (i_ser16 ? 5'd16 : 5'd14) : (i_ser16 ? 5'd8 : 5'd7);
  // lsb-first: reverse the valid msb-aligned bits on each wire [RULE17]
  function [15:0] orient;
    input [15:0] v;
    input [4:0] n;
    input lsbf;
    begin
      orient = lsbf ? (rev16(v) << (16 - n)) : v;
    end
  endfunction
  always @(posedge i_clk) begin
    if (i_srst) begin
      sh_al_r <= 16'h0000;
      sh_ah_r <= 16'h0000;
      sh_bl_r <= 16'h0000;
      sh_bh_r <= 16'h0000;
      toggle_r <= 1'b0;
      word_odd_r <= 1'b0;
    end else if (i_frame_tick) begin
      toggle_r <= ~toggle_r; // [RULE8]
      word_odd_r <= ~word_odd_r;
      if (i_bit_order == `ASTPG_ORD_WORD && i_if_mode != `ASTPG_IF_1W_DDR && !is_sync) begin
        // word-wise: even samples on low wires, odd on high wires
        if (!word_odd_r) begin
          sh_al_r <= orient(ld_al, nbits, i_lsb_first);
          sh_bl_r <= orient(ld_bl, nbits, i_lsb_first);
        end else begin
          sh_ah_r <= orient(ld_ah, nbits, i_lsb_first);
          sh_bh_r <= orient(ld_bh, nbits, i_lsb_first);
        end
      end else begin
        sh_al_r <= orient(ld_al, nbits, i_lsb_first); // [RULE11] [RULE18]
        sh_ah_r <= orient(ld_ah, nbits, i_lsb_first);
        sh_bl_r <= orient(ld_bl, nbits, i_lsb_first);
        sh_bh_r <= orient(ld_bh, nbits, i_lsb_first);
      end
    end else begin
      sh_al_r <= {sh_al_r[14:0], 1'b0};
      sh_ah_r <= {sh_ah_r[14:0], 1'b0};
      sh_bl_r <= {sh_bl_r[14:0], 1'b0};
      sh_bh_r <= {sh_bh_r[14:0], 1'b0};
    end
  end
  // ----------------------------------------
  // output stage
  // ----------------------------------------
  reg deskew_r;
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_chan_a_wire_low <= 1'b0;
      o_chan_a_wire_high <= 1'b0;
      o_chan_b_wire_low <= 1'b0;
      o_chan_b_wire_high <= 1'b0;
      o_serial_bit_clock_out <= 1'b0;
      o_frame_clock <= 1'b0;
      deskew_r <= 1'b0;
    end else begin
      deskew_r <= ~deskew_r;
      // bit clock toggles each bit on the same i_clk edge as the data; no half-bit skew is applied [RULE1] [RULE18]
      o_serial_bit_clock_out <= ~o_serial_bit_clock_out; // [RULE1]
      o_frame_clock <= i_frame_tick ? 1'b1 : (o_frame_clock & ~i_frame_tick & 1'b0);
      if (i_pattern_sel == `ASTPG_PAT_DESKEW) begin
        o_chan_a_wire_low <= ~deskew_r; // [RULE2] [RULE6]
        o_chan_a_wire_high <= ~deskew_r;
        o_chan_b_wire_low <= ~deskew_r;
        o_chan_b_wire_high <= ~deskew_r;
      end else if (is_const) begin
        o_chan_a_wire_low <= const_bit; // [RULE7] [RULE6]
        o_chan_a_wire_high <= const_bit;
        o_chan_b_wire_low <= const_bit;
        o_chan_b_wire_high <= const_bit;
      end else begin
        // last bit of a word leaves on the tick edge itself
        o_chan_a_wire_low <= sh_al_r[15];
        o_chan_a_wire_high <= sh_ah_r[15];
        o_chan_b_wire_low <= sh_bl_r[15];
        o_chan_b_wire_high <= sh_bh_r[15];
      end
    end
  end
endmodule // astpg_gen

// file: bench/astpg_gen_sva.sv
// astpg_gen_sva.sv: port assertions for astpg_gen
// assumes: bound into astpg_gen; config only changes while in reset
`timescale 1ns/1ps
`include "astpg_defs.vh"
module astpg_gen_sva #(
  parameter DW = 14
) (
  // clock and reset
  input wire i_clk,
  input wire i_srst,
  input wire i_frame_tick,
  // samples
  input wire [DW-1:0] i_sample_a,
  input wire [DW-1:0] i_sample_b,
  // configuration
  input wire [2:0] i_pattern_sel,
  input wire [1:0] i_if_mode,
  input wire i_ser16,
  input wire [1:0] i_bit_order,
  input wire i_lsb_first,
  input wire i_clock_prop_delay_ge_ts,
  input wire [7:0] i_custom_hi,
  input wire [5:0] i_custom_lo,
  // serial outputs
  input wire o_serial_bit_clock_out,
  input wire o_frame_clock,
  input wire o_chan_a_wire_low,
  input wire o_chan_a_wire_high,
  input wire o_chan_b_wire_low,
  input wire o_chan_b_wire_high
);
  reg [8:0] age_r;
  wire ok = (age_r >= 9'h12c);
  wire t14 = ok & (i_if_mode == `ASTPG_IF_1W_DDR) & !i_ser16 & !i_lsb_first & i_frame_tick;
  wire al = o_chan_a_wire_low;
  always @(posedge i_clk) begin
    if (i_srst) age_r <= 9'h0;
    else if (age_r != 9'h1ff) age_r <= age_r + 9'h1;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  bit_clock_toggle_a: assert property (1'b1 |=> o_serial_bit_clock_out != $past(o_serial_bit_clock_out))
    else $error("bit clock did not toggle");
  frame_mark_a: assert property (i_frame_tick |=> o_frame_clock ##1 !o_frame_clock)
    else $error("frame clock pulse wrong");
  zeros_hold_a: assert property (ok && i_pattern_sel == `ASTPG_PAT_ZEROS |->
    !(al | o_chan_a_wire_high | o_chan_b_wire_low | o_chan_b_wire_high)) else $error("zeros mode wire high");
  ones_hold_a: assert property (ok && i_pattern_sel == `ASTPG_PAT_ONES |-> al && o_chan_b_wire_low &&
    (i_if_mode == `ASTPG_IF_1W_DDR || o_chan_a_wire_high && o_chan_b_wire_high)) else $error("ones mode wire low");
  deskew_alt_a: assert property (ok && i_pattern_sel == `ASTPG_PAT_DESKEW |=> al != $past(al))
    else $error("deskew bits repeat");
  chan_same_a: assert property (ok && i_pattern_sel != `ASTPG_PAT_NONE |->
    al == o_chan_b_wire_low && o_chan_a_wire_high == o_chan_b_wire_high) else $error("channels differ");
  toggle_word_a: assert property (t14 && i_pattern_sel == `ASTPG_PAT_TOGGLE |-> ##3 al != $past(al, 14))
    else $error("toggle word did not invert");
  sync_word_a: assert property (t14 && i_pattern_sel == `ASTPG_PAT_SYNC |-> ##2 al [*7] ##1 !al [*7])
    else $error("sync word wrong");
  custom_ends_a: assert property (t14 && i_pattern_sel == `ASTPG_PAT_CUSTOM |->
    ##2 al == i_custom_hi[7] ##13 al == i_custom_lo[0]) else $error("custom word ends wrong");
endmodule // astpg_gen_sva

// file: bench/astpg_rx_model.sv
// astpg_rx_model.sv: receiver deserializer for one data wire
// assumes: last bit of a word shows one edge after the next frame tick
`timescale 1ns/1ps
module astpg_rx_model (
  // clock and framing
  input wire i_clk,
  input wire i_tick,
  // serial data
  input wire i_wire,
  // captured word
  output reg o_valid,
  output reg [15:0] o_word
);
  reg [15:0] sh_r;
  reg tk_r;
  always @(posedge i_clk) begin
    sh_r <= {sh_r[14:0], i_wire};
    tk_r <= i_tick;
    o_valid <= tk_r;
    if (tk_r) o_word <= {sh_r[14:0], i_wire};
  end
endmodule // astpg_rx_model

// file: bench/astpg_gen_tb.sv
// astpg_gen_tb.sv: random and corner scenarios for astpg_gen
// assumes: first serial bit two edges after its frame tick, one bit per clock
`timescale 1ns/1ps
`include "astpg_defs.vh"
module astpg_gen_tb;
  reg clk = 1'b0, srst = 1'b1, tick = 1'b0, s16 = 1'b0, lsb = 1'b0, pd = 1'b0, chk = 1'b0;
  reg [13:0] sa = 14'h0, sb = 14'h0, cw = 14'h0;
  reg [2:0] sel = 3'h0;
  reg [1:0] ifm = 2'h0, ord = 2'h0, nxt_ord = 2'h0;
  reg [31:0] r;
  reg [13:0] ha [0:4095];
  reg [13:0] hb [0:4095];
  wire bck, fck, al, ah, bl, bh, lv, hv;
  wire [15:0] lw, hw;
  integer seed = 45583, bad_count = 0, samples_checked = 0, tn = 0, cnt = 0, lat = 0;
  wire [4:0] nb = (ifm == `ASTPG_IF_1W_DDR) ? (s16 ? 5'h10 : 5'he) : (s16 ? 5'h8 : 5'h7);
  wire [15:0] msk = (16'h1 << nb) - 16'h1;
  astpg_gen astpg_gen_i (.i_clk(clk), .i_srst(srst), .i_frame_tick(tick), .i_sample_a(sa), .i_sample_b(sb),
    .i_pattern_sel(sel), .i_if_mode(ifm), .i_ser16(s16), .i_bit_order(ord), .i_lsb_first(lsb),
    .i_clock_prop_delay_ge_ts(pd), .i_custom_hi(cw[13:6]), .i_custom_lo(cw[5:0]), .o_serial_bit_clock_out(bck),
    .o_frame_clock(fck), .o_chan_a_wire_low(al), .o_chan_a_wire_high(ah), .o_chan_b_wire_low(bl),
    .o_chan_b_wire_high(bh));
  astpg_rx_model rx_lo_i (.i_clk(clk), .i_tick(tick), .i_wire(al), .o_valid(lv), .o_word(lw));
  astpg_rx_model rx_hi_i (.i_clk(clk), .i_tick(tick), .i_wire(bh), .o_valid(hv), .o_word(hw));
  always #12.5 clk = ~clk;
  function [15:0] exp_w(input hi, input [13:0] smp);
    reg [13:0] w;
    reg [15:0] v;
    integer k;
    begin
      w = (sel == `ASTPG_PAT_CUSTOM) ? cw : smp;
      v = (ifm == `ASTPG_IF_1W_DDR) ? {2'h0, w} : {9'h0, hi ? w[13:7] : w[6:0]};
      if (ifm != `ASTPG_IF_1W_DDR && ord == `ASTPG_ORD_BIT) for (k = 0; k < 7; k = k + 1) v[k] = w[2 * k + hi];
      if (sel == `ASTPG_PAT_ZEROS) v = 16'h0;
      if (sel == `ASTPG_PAT_ONES) v = msk;
      if (sel == `ASTPG_PAT_SYNC) v = (ifm == `ASTPG_IF_1W_DDR) ? (s16 ? `ASTPG_SYNC_1W16 : {2'h0, `ASTPG_SYNC_1W14})
        : (s16 ? {8'h0, `ASTPG_SYNC_2W16} : {9'h0, `ASTPG_SYNC_2W14});
      exp_w = v;
      for (k = 0; k < nb; k = k + 1) if (lsb) exp_w[k] = v[nb - 1 - k];
    end
  endfunction
  task check(input [8*4-1:0] what, input [15:0] seen, input [15:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("MISMATCH %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  always @(posedge clk) begin
    r = $random(seed);
    sa <= r[13:0];
    sb <= r[29:16];
    tick <= (cnt == 0);
    cnt <= (cnt >= nb - 1) ? 0 : cnt + 1;
    if (tick) begin
      ha[tn % 4096] = sa;
      hb[tn % 4096] = sb;
      tn = tn + 1;
    end
    if (chk && lv && sel != `ASTPG_PAT_TOGGLE && sel != `ASTPG_PAT_DESKEW) begin
      check("low", lw & msk, exp_w(1'b0, ha[(tn - 14 - lat) % 4096]));
      if (ifm != `ASTPG_IF_1W_DDR) check("high", hw & msk, exp_w(1'b1, hb[(tn - 14 - lat) % 4096]));
    end
  end
  task run(input [2:0] p, input [1:0] m, input s, input l, input d, input integer lt, input [13:0] c);
    begin
      @(posedge clk);
      srst <= 1'b1;
      sel <= p;
      ifm <= m;
      s16 <= s;
      lsb <= l;
      pd <= d;
      ord <= nxt_ord;
      lat <= lt;
      cw <= c;
      chk <= 1'b0;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      repeat (300) @(posedge clk);
      chk <= 1'b1;
      repeat (200) @(posedge clk);
    end
  endtask
  task conclude;
    begin
      if (bad_count == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    run(`ASTPG_PAT_ZEROS, `ASTPG_IF_1W_DDR, 0, 0, 0, 0, 14'h0);
    run(`ASTPG_PAT_ONES, `ASTPG_IF_2W_SDR, 1, 0, 0, 0, 14'h0);
    run(`ASTPG_PAT_ONES, `ASTPG_IF_1W_DDR, 0, 0, 0, 0, 14'h0);
    run(`ASTPG_PAT_DESKEW, `ASTPG_IF_1W_DDR, 0, 0, 0, 0, 14'h0);
    run(`ASTPG_PAT_TOGGLE, `ASTPG_IF_1W_DDR, 0, 0, 0, 0, 14'h0);
    run(`ASTPG_PAT_CUSTOM, `ASTPG_IF_1W_DDR, 0, 0, 0, 0, 14'h2001);
    run(`ASTPG_PAT_CUSTOM, `ASTPG_IF_1W_DDR, 0, 1, 0, 0, 14'h2001);
    run(`ASTPG_PAT_CUSTOM, `ASTPG_IF_1W_DDR, 1, 0, 0, 0, r[13:0]);
    run(`ASTPG_PAT_CUSTOM, `ASTPG_IF_2W_SDR, 0, 1, 0, 0, r[20:7]);
    run(`ASTPG_PAT_CUSTOM, `ASTPG_IF_2W_DDR, 1, 0, 1, 0, r[15:2]);
    run(`ASTPG_PAT_SYNC, `ASTPG_IF_1W_DDR, 0, 0, 0, 0, 14'h0);
    run(`ASTPG_PAT_SYNC, `ASTPG_IF_1W_DDR, 1, 0, 0, 0, 14'h0);
    run(`ASTPG_PAT_SYNC, `ASTPG_IF_2W_DDR, 0, 0, 0, 0, 14'h0);
    run(`ASTPG_PAT_SYNC, `ASTPG_IF_2W_SDR, 1, 0, 0, 0, 14'h0);
    run(`ASTPG_PAT_NONE, `ASTPG_IF_1W_DDR, 0, 0, 0, 0, 14'h0);
    run(`ASTPG_PAT_NONE, `ASTPG_IF_1W_DDR, 1, 0, 0, 0, 14'h0);
    run(`ASTPG_PAT_NONE, `ASTPG_IF_2W_DDR, 0, 0, 1, 2, 14'h0);
    run(`ASTPG_PAT_NONE, `ASTPG_IF_2W_DDR, 0, 0, 0, 1, 14'h0);
    run(`ASTPG_PAT_NONE, `ASTPG_IF_2W_DDR, 1, 0, 1, 1, 14'h0);
    run(`ASTPG_PAT_NONE, `ASTPG_IF_2W_DDR, 1, 0, 0, 0, 14'h0);
    run(`ASTPG_PAT_NONE, `ASTPG_IF_2W_SDR, 1, 1, 0, 0, 14'h0);
    nxt_ord = `ASTPG_ORD_BIT;
    run(`ASTPG_PAT_NONE, `ASTPG_IF_2W_SDR, 0, 0, 0, 0, 14'h0);
    run(`ASTPG_PAT_CUSTOM, `ASTPG_IF_2W_DDR, 1, 1, 0, 0, r[13:0]);
    conclude;
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count = bad_count + 1;
    conclude;
  end
endmodule // astpg_gen_tb
bind astpg_gen astpg_gen_sva #(.DW(DW)) astpg_gen_sva_i (.i_clk(i_clk), .i_srst(i_srst), .i_frame_tick(i_frame_tick),
  .i_sample_a(i_sample_a), .i_sample_b(i_sample_b), .i_pattern_sel(i_pattern_sel), .i_if_mode(i_if_mode),
  .i_ser16(i_ser16), .i_bit_order(i_bit_order), .i_lsb_first(i_lsb_first),
  .i_clock_prop_delay_ge_ts(i_clock_prop_delay_ge_ts), .i_custom_hi(i_custom_hi), .i_custom_lo(i_custom_lo),
  .o_serial_bit_clock_out(o_serial_bit_clock_out), .o_frame_clock(o_frame_clock),
  .o_chan_a_wire_low(o_chan_a_wire_low), .o_chan_a_wire_high(o_chan_a_wire_high),
  .o_chan_b_wire_low(o_chan_b_wire_low), .o_chan_b_wire_high(o_chan_b_wire_high));
